// ### hdl/paired_channel_pulse_pwm_timer.v
`timescale 1ns/100ps
// Function
// - a valid trigger edge while the master is idle loads master counter from data, then counts down
// - one-shot master at zero raises its event and stops until next edge
// - master event starts slave: slave loads its data and counts down
// - output active one count clock after master event, inactive at zero
// - start bits self-clear and set both enable-status bits
// - master start in pwm mode raises the master event, starting the slave
// - stop bits self-clear, clear enable status, freeze both counters
// - stop leaves the slave output level untouched
// - both counters readable at any time; no overflow status used
// - pwm period is master data plus one count clocks
// - pwm duty is slave data over master data plus one; zero is off
// - slave data above master data saturates output fully active
// - pwm start raises master event, loads master counter, counts down
// - pwm master at zero raises event, reloads, repeats until stopped
// - pwm slave at zero raises its event and idles until master event
// - output mode bit set selects set and reset timing from events
// - while stopped the pin holds its last level until software writes a new one
// - unit enable low ignores all writes but the control register and resets all channel logic
// - prescaler register sets the two prescaled count clock rates
// - pair is even master channel plus next higher slave channel
// - one-shot delay is master data plus two; width is slave data
// - software master start also triggers a one-shot pulse
`include "pwm_timer_defines.vh"

module paired_channel_pulse_pwm_timer (
    input wire pclk,
    input wire presetn,
    input wire [`ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`DATA_W-1:0] pwdata,
    output wire [`DATA_W-1:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire trigger_input_pin,
    output wire slave_output_pin,
    output wire slave_output_oe,
    output wire master_terminal_event,
    output wire slave_terminal_event
);

////////////////////////////////////////////////////////////////////////////
// register state

reg unit_en_ff;
reg [`PSC_W-1:0] psc_ff;
reg [`MODE_W-1:0] mode_ff;
reg [`CNT_W-1:0] master_data_value_ff;
reg [`CNT_W-1:0] slave_data_value_ff;
reg out_level_ff;
reg out_enable_ff;
reg out_mode_ff;
reg out_polarity_ff;
reg [`DATA_W-1:0] prdata_ff;
reg pready_ff;
reg pslverr_ff;
reg pin_oe_ff;
reg trig_prev_ff;

// channel state
reg master_enable_status_ff;
reg slave_enable_status_ff;
reg master_run_ff;
reg master_pend_ff;
reg slave_run_ff;
reg slave_pend_ff;
reg [`CNT_W-1:0] master_counter_ff;
reg [`CNT_W-1:0] slave_counter_ff;
reg master_evt_ff;
reg slave_evt_ff;
reg [`CNT_W-1:0] div_cnt_ff;

reg nxt_master_en;
reg nxt_slave_en;
reg nxt_master_run;
reg nxt_master_pend;
reg nxt_slave_run;
reg nxt_slave_pend;
reg [`CNT_W-1:0] nxt_master_cnt;
reg [`CNT_W-1:0] nxt_slave_cnt;
reg nxt_master_evt;
reg nxt_slave_evt;
reg nxt_out_level;
reg [`DATA_W-1:0] nxt_rdata;
reg nxt_err;

////////////////////////////////////////////////////////////////////////////
// apb decode

wire setup = psel & ~penable;
wire access = psel & penable & pready_ff;
wire wr = access & pwrite;
wire wr_ctrl = wr & (paddr == `OFS_CTRL);
// all other writes are ignored while the unit is off
wire wr_ok = wr & unit_en_ff;
wire wr_psc = wr_ok & (paddr == `OFS_PRESCALE);
wire wr_mode = wr_ok & (paddr == `OFS_MODE);
wire wr_start = wr_ok & (paddr == `OFS_START);
wire wr_stop = wr_ok & (paddr == `OFS_STOP);
wire wr_mdata = wr_ok & (paddr == `OFS_MASTER_DATA);
wire wr_sdata = wr_ok & (paddr == `OFS_SLAVE_DATA);
wire wr_out = wr_ok & (paddr == `OFS_OUTPUT);

// trigger bits are never stored, so they read back as zero
wire start_master = wr_start & pwdata[`TRIG_MASTER];
wire start_slave = wr_start & pwdata[`TRIG_SLAVE];
wire stop_master = wr_stop & pwdata[`TRIG_MASTER];
wire stop_slave = wr_stop & pwdata[`TRIG_SLAVE];

wire pwm_mode = mode_ff[`MODE_PWM];

////////////////////////////////////////////////////////////////////////////
// prescaled count clock enables

wire [`NUM_CLK-1:0] tick;

// one enable pulse per prescaled clock, rate pclk over two to the field
genvar gi;
generate
    for (gi = 0; gi < `NUM_CLK; gi = gi + 1) begin : g_clk
        wire [`PSC_FIELD_W-1:0] sel;
        wire [`CNT_W-1:0] mask;
        assign sel = psc_ff[gi*`PSC_FIELD_W +: `PSC_FIELD_W];
        assign mask = ~({`CNT_W{1'b1}} << sel);
        assign tick[gi] = &(div_cnt_ff | ~mask);
    end
endgenerate

// master is channel 0 of the pair, slave the next one up
wire master_tick = mode_ff[`MODE_MASTER_CLK] ? tick[1] : tick[0];
wire slave_tick = mode_ff[`MODE_SLAVE_CLK] ? tick[1] : tick[0];

// free running divider, cleared while the unit is off
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        div_cnt_ff <= `CNT_ZERO;
    end else if (!unit_en_ff) begin
        div_cnt_ff <= `CNT_ZERO;
    end else begin
        div_cnt_ff <= div_cnt_ff + `CNT_ONE;
    end
end

////////////////////////////////////////////////////////////////////////////
// trigger edge detection

// edge select: 00 falling, 01 rising, 1x both
wire rise = trigger_input_pin & ~trig_prev_ff;
wire fall = ~trigger_input_pin & trig_prev_ff;
wire valid_edge = mode_ff[`MODE_EDGE_HIGH] ? (rise | fall) :
    (mode_ff[`MODE_EDGE_LOW] ? rise : fall);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        trig_prev_ff <= 1'b0;
    end else begin
        trig_prev_ff <= trigger_input_pin;
    end
end

// slave data at or above master data plus one saturates
wire [`CNT_W:0] period_len = {1'b0, master_data_value_ff} + 17'h00001;
wire saturate = pwm_mode & ({1'b0, slave_data_value_ff} >= period_len);

wire level_active = ~out_polarity_ff;
wire level_idle = out_polarity_ff;

////////////////////////////////////////////////////////////////////////////
// channel next state

always @* begin
    nxt_master_en = master_enable_status_ff;
    nxt_slave_en = slave_enable_status_ff;
    nxt_master_run = master_run_ff;
    nxt_master_pend = master_pend_ff;
    nxt_slave_run = slave_run_ff;
    nxt_slave_pend = slave_pend_ff;
    nxt_master_cnt = master_counter_ff;
    nxt_slave_cnt = slave_counter_ff;
    nxt_master_evt = 1'b0;
    nxt_slave_evt = 1'b0;
    nxt_out_level = wr_out ? pwdata[`OUT_LEVEL] : out_level_ff;
    // master channel
    if (stop_master) begin
        // counter keeps its value
        nxt_master_en = 1'b0;
        nxt_master_run = 1'b0;
        nxt_master_pend = 1'b0;
    end else if (start_master) begin
        nxt_master_en = 1'b1;
        if (pwm_mode) begin
            nxt_master_evt = 1'b1;
            nxt_master_cnt = master_data_value_ff;
            nxt_master_run = 1'b1;
        end else if (!master_run_ff) begin
            nxt_master_pend = 1'b1;
        end
    end else if (master_enable_status_ff) begin
        if (master_tick) begin
            if (master_pend_ff) begin
                nxt_master_cnt = master_data_value_ff;
                nxt_master_run = 1'b1;
                nxt_master_pend = 1'b0;
            end else if (master_run_ff) begin
                if (master_counter_ff == `CNT_ZERO) begin
                    nxt_master_evt = 1'b1;
                    if (pwm_mode) begin
                        nxt_master_cnt = master_data_value_ff;
                    end else begin
                        nxt_master_run = 1'b0;
                    end
                end else begin
                    nxt_master_cnt = master_counter_ff - `CNT_ONE;
                end
            end
        end
        // one-shot edges are only accepted while idle
        if (!pwm_mode && valid_edge && !master_run_ff) begin
            nxt_master_pend = 1'b1;
        end
    end
    // slave channel
    if (stop_slave) begin
        nxt_slave_en = 1'b0;
        nxt_slave_run = 1'b0;
        nxt_slave_pend = 1'b0;
    end else if (start_slave) begin
        nxt_slave_en = 1'b1;
        if (nxt_master_evt) begin
            nxt_slave_pend = 1'b1;
        end
    end else if (slave_enable_status_ff) begin
        if (slave_tick && slave_pend_ff) begin
            // load happens one count clock after the master event
            nxt_slave_cnt = slave_data_value_ff;
            nxt_slave_pend = 1'b0;
            if (slave_data_value_ff == `CNT_ZERO) begin
                nxt_slave_run = 1'b0;
                nxt_slave_evt = 1'b1;
                if (out_mode_ff) begin
                    nxt_out_level = level_idle;
                end
            end else begin
                nxt_slave_run = 1'b1;
                if (out_mode_ff) begin
                    nxt_out_level = level_active;
                end
            end
        end else if (slave_tick && slave_run_ff) begin
            if (slave_counter_ff > `CNT_ONE) begin
                nxt_slave_cnt = slave_counter_ff - `CNT_ONE;
            end else if (!saturate) begin
                nxt_slave_cnt = `CNT_ZERO;
                nxt_slave_run = 1'b0;
                nxt_slave_evt = 1'b1;
                if (out_mode_ff) begin
                    nxt_out_level = level_idle;
                end
            end
        end
        // set wins over the load that clears the pending flag
        if (nxt_master_evt) begin
            nxt_slave_pend = 1'b1;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// channel flops

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        master_enable_status_ff <= 1'b0;
        slave_enable_status_ff <= 1'b0;
        master_run_ff <= 1'b0;
        master_pend_ff <= 1'b0;
        slave_run_ff <= 1'b0;
        slave_pend_ff <= 1'b0;
        master_counter_ff <= `CNT_ZERO;
        slave_counter_ff <= `CNT_ZERO;
        master_evt_ff <= 1'b0;
        slave_evt_ff <= 1'b0;
        out_level_ff <= 1'b0;
    end else if (!unit_en_ff) begin
        master_enable_status_ff <= 1'b0;
        slave_enable_status_ff <= 1'b0;
        master_run_ff <= 1'b0;
        master_pend_ff <= 1'b0;
        slave_run_ff <= 1'b0;
        slave_pend_ff <= 1'b0;
        master_counter_ff <= `CNT_ZERO;
        slave_counter_ff <= `CNT_ZERO;
        master_evt_ff <= 1'b0;
        slave_evt_ff <= 1'b0;
        out_level_ff <= 1'b0;
    end else begin
        master_enable_status_ff <= nxt_master_en;
        slave_enable_status_ff <= nxt_slave_en;
        master_run_ff <= nxt_master_run;
        master_pend_ff <= nxt_master_pend;
        slave_run_ff <= nxt_slave_run;
        slave_pend_ff <= nxt_slave_pend;
        master_counter_ff <= nxt_master_cnt;
        slave_counter_ff <= nxt_slave_cnt;
        master_evt_ff <= nxt_master_evt;
        slave_evt_ff <= nxt_slave_evt;
        // software level holds while stopped
        out_level_ff <= nxt_out_level;
    end
end

////////////////////////////////////////////////////////////////////////////
// software registers

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        unit_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
        unit_en_ff <= pwdata[`CTRL_UNIT_EN];
    end
end

// configuration, cleared while the unit is off
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        psc_ff <= `PSC_RESET;
        mode_ff <= `MODE_RESET;
        master_data_value_ff <= `CNT_ZERO;
        slave_data_value_ff <= `CNT_ZERO;
        out_enable_ff <= 1'b0;
        out_mode_ff <= 1'b0;
        out_polarity_ff <= 1'b0;
        pin_oe_ff <= 1'b0;
    end else if (!unit_en_ff) begin
        psc_ff <= `PSC_RESET;
        mode_ff <= `MODE_RESET;
        master_data_value_ff <= `CNT_ZERO;
        slave_data_value_ff <= `CNT_ZERO;
        out_enable_ff <= 1'b0;
        out_mode_ff <= 1'b0;
        out_polarity_ff <= 1'b0;
        pin_oe_ff <= 1'b0;
    end else begin
        if (wr_psc) begin
            psc_ff <= pwdata[`PSC_W-1:0];
        end
        if (wr_mode) begin
            mode_ff <= pwdata[`MODE_W-1:0];
        end
        if (wr_mdata) begin
            master_data_value_ff <= pwdata[`CNT_W-1:0];
        end
        if (wr_sdata) begin
            slave_data_value_ff <= pwdata[`CNT_W-1:0];
        end
        if (wr_out) begin
            out_enable_ff <= pwdata[`OUT_ENABLE];
            out_mode_ff <= pwdata[`OUT_MODE];
            out_polarity_ff <= pwdata[`OUT_POLARITY];
        end
        pin_oe_ff <= out_enable_ff;
    end
end

////////////////////////////////////////////////////////////////////////////
// apb read and response

always @* begin
    nxt_rdata = `WORD_ZERO;
    nxt_err = 1'b0;
    case (paddr)
        `OFS_CTRL: nxt_rdata[`CTRL_UNIT_EN] = unit_en_ff;
        `OFS_PRESCALE: nxt_rdata[`PSC_W-1:0] = psc_ff;
        `OFS_MODE: nxt_rdata[`MODE_W-1:0] = mode_ff;
        `OFS_START: nxt_rdata = `WORD_ZERO;
        `OFS_STOP: nxt_rdata = `WORD_ZERO;
        `OFS_STATUS: begin
            nxt_rdata[`STAT_MASTER_EN] = master_enable_status_ff;
            nxt_rdata[`STAT_SLAVE_EN] = slave_enable_status_ff;
            nxt_rdata[`STAT_MASTER_RUN] = master_run_ff;
            nxt_rdata[`STAT_SLAVE_RUN] = slave_run_ff;
        end
        `OFS_MASTER_DATA: nxt_rdata[`CNT_W-1:0] = master_data_value_ff;
        `OFS_SLAVE_DATA: nxt_rdata[`CNT_W-1:0] = slave_data_value_ff;
        `OFS_MASTER_COUNT: nxt_rdata[`CNT_W-1:0] = master_counter_ff;
        `OFS_SLAVE_COUNT: nxt_rdata[`CNT_W-1:0] = slave_counter_ff;
        `OFS_OUTPUT: begin
            nxt_rdata[`OUT_LEVEL] = out_level_ff;
            nxt_rdata[`OUT_ENABLE] = out_enable_ff;
            nxt_rdata[`OUT_MODE] = out_mode_ff;
            nxt_rdata[`OUT_POLARITY] = out_polarity_ff;
        end
        default: nxt_err = 1'b1;
    endcase
end

// answer is prepared in the setup cycle, so access needs no wait
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        prdata_ff <= `WORD_ZERO;
        pslverr_ff <= 1'b0;
        pready_ff <= 1'b0;
    end else begin
        pready_ff <= 1'b1;
        if (setup) begin
            prdata_ff <= pwrite ? `WORD_ZERO : nxt_rdata;
            pslverr_ff <= nxt_err;
        end else if (access | ~psel) begin
            // error stands for the access cycle only
            pslverr_ff <= 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// outputs

assign prdata = prdata_ff;
assign pready = pready_ff;
assign pslverr = pslverr_ff;
assign slave_output_pin = out_level_ff;
assign slave_output_oe = pin_oe_ff;
assign master_terminal_event = master_evt_ff;
assign slave_terminal_event = slave_evt_ff;

endmodule

// ### hdl/pwm_timer_defines.vh
`ifndef PWM_TIMER_DEFINES_VH
`define PWM_TIMER_DEFINES_VH

// apb register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PRESCALE 8'h04
`define OFS_MODE 8'h08
`define OFS_START 8'h0c
`define OFS_STOP 8'h10
`define OFS_STATUS 8'h14
`define OFS_MASTER_DATA 8'h18
`define OFS_SLAVE_DATA 8'h1c
`define OFS_MASTER_COUNT 8'h20
`define OFS_SLAVE_COUNT 8'h24
`define OFS_OUTPUT 8'h28

// widths
`define ADDR_W 8
`define DATA_W 32
`define CNT_W 16
`define PSC_W 8
`define PSC_FIELD_W 4
`define NUM_CLK 2

// control register bits
`define CTRL_UNIT_EN 0

// mode register bits
`define MODE_PWM 0
`define MODE_MASTER_CLK 1
`define MODE_SLAVE_CLK 2
`define MODE_EDGE_LOW 3
`define MODE_EDGE_HIGH 4
`define MODE_W 5

// start and stop trigger bits
`define TRIG_MASTER 0
`define TRIG_SLAVE 1

// status register bits
`define STAT_MASTER_EN 0
`define STAT_SLAVE_EN 1
`define STAT_MASTER_RUN 2
`define STAT_SLAVE_RUN 3

// output register bits
`define OUT_LEVEL 0
`define OUT_ENABLE 1
`define OUT_MODE 2
`define OUT_POLARITY 3
`define OUT_W 4

// reset values and count constants
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define PSC_RESET 8'h00
`define MODE_RESET 5'h00
`define OUT_RESET 4'h0
`define WORD_ZERO 32'h00000000

`endif

// ### verif/pin_partner.sv
`timescale 1ns/100ps
// trigger source and pulse width meter on the pin side
module pin_partner (
    input wire pclk,
    input wire slave_output_pin,
    output logic trigger_input_pin,
    output logic [15:0] width,
    output logic width_vld
);
    logic [15:0] cnt_ff = 16'h0000;
    initial trigger_input_pin = 1'b0;
    // flip the trigger line just after an edge
    task automatic toggle();
        @(posedge pclk);
        trigger_input_pin <= ~trigger_input_pin;
    endtask
    // measure each active pulse, report it when it ends
    always @(posedge pclk) begin
        width_vld <= 1'b0;
        if (slave_output_pin === 1'b1) begin
            cnt_ff <= cnt_ff + 16'h0001;
        end else begin
            width <= cnt_ff;
            width_vld <= (cnt_ff != 16'h0000);
            cnt_ff <= 16'h0000;
        end
    end
endmodule

// ### verif/pwm_timer_monitor.sv
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"
// port checks for the paired timer
module pwm_timer_monitor (
    input wire pclk,
    input wire presetn,
    input wire [`ADDR_W-1:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`DATA_W-1:0] pwdata,
    input wire [`DATA_W-1:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire trigger_input_pin,
    input wire slave_output_pin,
    input wire slave_output_oe,
    input wire master_terminal_event,
    input wire slave_terminal_event
);
    logic [15:0] since_m_ff;
    logic [15:0] nxt_since_m;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    // cycles since the last master event
    assign nxt_since_m = master_terminal_event ? 16'h0000 :
        (&since_m_ff ? since_m_ff : since_m_ff + 16'h0001);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            since_m_ff <= 16'hffff;
        else
            since_m_ff <= nxt_since_m;
    end
    ////////////////////////////////////////
    sequence apb_acc;
        psel && penable;
    endsequence
    sequence m_pulse;
        master_terminal_event ##1 !master_terminal_event;
    endsequence
    zero_wait_a: assert property (apb_acc |-> pready)
        else $error("access phase without ready");
    err_access_a: assert property (pslverr |-> apb_acc ##0 prdata == 0)
        else $error("error outside access or with data");
    ready_after_rst_a: assert property ($rose(presetn) |->
        !pready && !slave_output_pin && !slave_output_oe)
        else $error("outputs not cleared by reset");
    master_pulse_a: assert property (master_terminal_event |-> m_pulse)
        else $error("master event longer than one cycle");
    slave_pulse_a: assert property (slave_terminal_event |=>
        !slave_terminal_event) else $error("slave event too long");
    rise_after_m_a: assert property ($rose(slave_output_pin) |->
        since_m_ff <= 16'd4) else $error("output rise not after event");
    fall_at_end_a: assert property ($fell(slave_output_pin) |->
        slave_terminal_event) else $error("output fall without end");
    slave_after_m_a: assert property (slave_terminal_event |->
        since_m_ff <= 16'd600) else $error("slave end without start");
    pin_hold_a: assert property ($changed(slave_output_pin) |->
        since_m_ff <= 16'd4 || slave_terminal_event)
        else $error("output moved while idle");
endmodule

// ### verif/tb_paired_channel_pulse_pwm_timer.sv
`timescale 1ns/100ps
`include "pwm_timer_defines.vh"
module tb_paired_channel_pulse_pwm_timer;
    logic pclk, presetn, psel, penable, pwrite;
    logic [`ADDR_W-1:0] paddr;
    logic [`DATA_W-1:0] pwdata;
    wire [`DATA_W-1:0] prdata;
    wire pready, pslverr, trigger_input_pin, slave_output_pin;
    wire slave_output_oe, master_terminal_event, slave_terminal_event;
    wire [15:0] width;
    wire width_vld;
    int failures, n_tests, cnt;
    logic [32:0] exp_rd[$];
    logic [31:0] msk_rd[$];
    logic [15:0] exp_w[$];
    logic [15:0] mv, sv;
    logic [1:0] sel_tab[3] = '{2'b01, 2'b00, 2'b10};
    logic [5:0] hit = 6'b111001;

    paired_channel_pulse_pwm_timer i_dut (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
        .trigger_input_pin, .slave_output_pin, .slave_output_oe,
        .master_terminal_event, .slave_terminal_event);
    pin_partner i_pin (.pclk, .slave_output_pin, .trigger_input_pin,
        .width, .width_vld);
    ////////////////////////////////////////
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (failures == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // one apb transfer, waits for ready
    task automatic apb(input logic [7:0] a, input logic w,
            input logic [31:0] d);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (pready !== 1'b1 && cnt < 50);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] e,
            input logic [31:0] m);
        exp_rd.push_back(e);
        msk_rd.push_back(m);
        apb(a, 1'b0, 32'h0);
    endtask
    task automatic wait_s(output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (slave_terminal_event !== 1'b1 && n < 500);
    endtask
    task automatic hi_cnt(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(posedge pclk);
            h += (slave_output_pin === 1'b1);
        end
    endtask
    // pwm run of three periods, stopped with the output low
    task automatic pwm(input logic [15:0] m, input logic [15:0] s,
            input logic [7:0] p, input logic [4:0] md, input int k);
        apb(`OFS_PRESCALE, 1'b1, {24'h0, p});
        apb(`OFS_MODE, 1'b1, {27'h0, md});
        apb(`OFS_MASTER_DATA, 1'b1, {16'h0, m});
        apb(`OFS_SLAVE_DATA, 1'b1, {16'h0, s});
        exp_w.push_back(16'(s * k));
        apb(`OFS_START, 1'b1, 32'h3);
        chk(33'(master_terminal_event), 33'h1);
        wait_s(cnt);
        repeat (2) begin
            exp_w.push_back(16'(s * k));
            wait_s(cnt);
            chk(33'(cnt), 33'((m + 1) * k));
        end
        apb(`OFS_STOP, 1'b1, 32'h3);
    endtask
    ////////////////////////////////////////
    // read data and pulse widths against the oldest notes
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk({pslverr, prdata & msk_rd[0]}, exp_rd[0]);
            void'(exp_rd.pop_front());
            void'(msk_rd.pop_front());
        end
        if (width_vld === 1'b1) begin
            if (exp_w.size() == 0)
                chk(33'h1ffff, 33'h0);
            else
                chk(33'(width), 33'(exp_w.pop_front()));
        end
    end
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        #400000;
        failures++;
        report_and_stop();
    end
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        failures = 0;
        n_tests = 0;
        void'($urandom(32'hcbdc));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(`OFS_MODE, 1'b1, 32'h1f);
        rd(`OFS_MODE, 33'h0, '1);
        rd(8'h40, 33'h100000000, '1);
        apb(`OFS_CTRL, 1'b1, 32'h1);
        apb(`OFS_OUTPUT, 1'b1, 32'h6);
        rd(`OFS_OUTPUT, 33'h6, '1);
        @(posedge pclk);
        chk(33'(slave_output_oe), 33'h1);
        mv = 16'd4;
        sv = 16'd3;
        apb(`OFS_MODE, 1'b1, 32'h8);
        apb(`OFS_MASTER_DATA, 1'b1, {16'h0, mv});
        apb(`OFS_SLAVE_DATA, 1'b1, {16'h0, sv});
        exp_w.push_back(sv);
        apb(`OFS_START, 1'b1, 32'h3);
        rd(`OFS_START, 33'h0, '1);
        rd(`OFS_STATUS, 33'h3, 32'h3);
        repeat (30) @(posedge pclk);
        for (int i = 0; i < 6; i++) begin
            if (i % 2 == 0)
                apb(`OFS_MODE, 1'b1, {27'h0, sel_tab[i / 2], 3'h0});
            if (hit[i])
                exp_w.push_back(sv);
            i_pin.toggle();
            cnt = 0;
            while (slave_output_pin !== 1'b1 && cnt < 30) begin
                @(posedge pclk);
                cnt++;
            end
            chk(33'(hit[i] ? (cnt >= mv + 2 && cnt <= mv + 5) :
                cnt == 30), 33'h1);
            repeat (30) @(posedge pclk);
        end
        exp_w.push_back(sv);
        repeat (3) i_pin.toggle();
        repeat (40) @(posedge pclk);
        apb(`OFS_STOP, 1'b1, 32'h3);
        rd(`OFS_STATUS, 33'h0, 32'hf);
        pwm(16'd3, 16'd1, 8'h00, 5'h01, 1);
        pwm(16'd4, 16'd2, 8'h01, 5'h01, 2);
        pwm(16'd5, 16'd3, 8'h20, 5'h07, 4);
        mv = 16'(4 + $urandom % 8);
        sv = 16'(1 + $urandom % (mv - 16'd2));
        pwm(mv, sv, 8'h00, 5'h01, 1);
        apb(`OFS_PRESCALE, 1'b1, 32'hf);
        apb(`OFS_MASTER_DATA, 1'b1, 32'h7);
        apb(`OFS_START, 1'b1, 32'h3);
        apb(`OFS_STOP, 1'b1, 32'h3);
        rd(`OFS_MASTER_COUNT, 33'h7, '1);
        apb(`OFS_PRESCALE, 1'b1, 32'h0);
        apb(`OFS_MASTER_DATA, 1'b1, {16'h0, mv});
        apb(`OFS_SLAVE_DATA, 1'b1, 32'h0);
        apb(`OFS_START, 1'b1, 32'h3);
        hi_cnt(40, cnt);
        chk(33'(cnt), 33'h0);
        apb(`OFS_STOP, 1'b1, 32'h3);
        apb(`OFS_SLAVE_DATA, 1'b1, {16'h0, mv + 16'd1});
        apb(`OFS_START, 1'b1, 32'h3);
        repeat (4) @(posedge pclk);
        hi_cnt(40, cnt);
        chk(33'(cnt), 33'd40);
        apb(`OFS_STOP, 1'b1, 32'h3);
        hi_cnt(10, cnt);
        chk(33'(cnt), 33'd10);
        chk(33'(exp_w.size()), 33'h0);
        report_and_stop();
    end
endmodule

bind paired_channel_pulse_pwm_timer pwm_timer_monitor i_mon (.pclk,
    .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .trigger_input_pin, .slave_output_pin, .slave_output_oe,
    .master_terminal_event, .slave_terminal_event);
